// [rtl/rrse_pkg.sv]
/*
  Shared constants and types for the return, rotate and sleep execution block.
  Assumes an AHB-Lite master issuing single word transfers only.
*/
package rrse_pkg;
  localparam logic [9:0] RRSE_OFF_CMD = 10'h000;
  localparam logic [9:0] RRSE_OFF_STATUS = 10'h004;
  localparam logic [9:0] RRSE_OFF_WREG = 10'h008;
  localparam logic [9:0] RRSE_OFF_PC = 10'h00C;
  localparam logic [9:0] RRSE_OFF_STACK = 10'h010;
  localparam logic [9:0] RRSE_OFF_WDT = 10'h014;
  localparam int RRSE_FILE_SEL_BIT = 9;
  localparam int RRSE_CMD_W = 10;
  localparam int RRSE_STATUS_BUSY_POS = 4;
  localparam int RRSE_STACK_SP_POS = 16;
  localparam int RRSE_WDT_COUNT_POS = 8;
  localparam logic [2:0] RRSE_HSIZE_WORD = 3'h2;
  localparam logic RRSE_CARRY_RST = 1'h0;
  localparam logic RRSE_PD_RST = 1'h1;
  localparam logic RRSE_TO_RST = 1'h1;
  localparam logic [7:0] RRSE_WREG_RST = 8'h00;

  typedef enum logic [1:0] {
    RRSE_OP_RETURN = 2'h0,
    RRSE_OP_ROTATE_LEFT_CARRY = 2'h1,
    RRSE_OP_ROTATE_RIGHT_CARRY = 2'h2,
    RRSE_OP_SLEEP = 2'h3
  } rrse_op_t;

  typedef struct packed {
    rrse_op_t op;
    logic dest;
    logic [6:0] faddr;
  } rrse_cmd_t;

  typedef struct packed {
    logic asleep;
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic carry;
  } rrse_status_t;

  typedef enum logic [1:0] {
    RRSE_BUS_IDLE = 2'b01,
    RRSE_BUS_DATA = 2'b10
  } rrse_bus_t;

  typedef enum logic [1:0] {
    RRSE_EX_READY = 2'b01,
    RRSE_EX_REFILL = 2'b10
  } rrse_ex_t;
endpackage

// [rtl/rrse_core.sv]
/*
  Execution of return, rotate through carry and sleep, with PC, stack,
  W, a 128-byte register file and watchdog, all reached over AHB-Lite.
  Assumes single word transfers and one clock, hclk.
*/
// Overview of operation
// - Return pops stack into PC, flags untouched.
// - Return takes two cycles, second refills.
// - Rotate left: carry into bit0, bit7 out.
// - Rotate right: carry into bit7, bit0 out.
// - Destination bit picks W or the register.
// - Seven-bit address; rotates alter only carry.
// - Sleep clears the power-down flag.
// - Sleep sets the watchdog-expiry flag.
// - Sleep clears watchdog count and prescaler.
`timescale 1ns/10ps
module rrse_core
  import rrse_pkg::*;
#(
  parameter int STACK_DEPTH = 16,
  parameter int PC_W = 15
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic core_sleeping
);
  localparam int SPW = $clog2(STACK_DEPTH);

  rrse_bus_t bus_state_reg;
  rrse_ex_t ex_state_reg;
  rrse_status_t status_reg;
  rrse_cmd_t cmd;
  logic [9:0] addr_reg;
  logic wr_reg;
  logic size_ok_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic [7:0] file_mem [128];
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SPW-1:0] sp_reg;
  logic [SPW-1:0] sp_m1;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] stack_top_entry;
  logic [7:0] w_reg;
  logic [7:0] wdt_pre_reg;
  logic [7:0] wdt_cnt_reg;
  logic [7:0] file_q;
  logic [7:0] rot_val;
  logic rot_c;
  logic [31:0] rd_next;
  logic data_cycle, wr_now, rd_now, issue, do_rot, do_ret, do_sleep, wdt_timeout;

  assign data_cycle = (bus_state_reg == RRSE_BUS_DATA) && size_ok_reg;
  assign wr_now = data_cycle && wr_reg;
  assign rd_now = data_cycle && !wr_reg;
  assign cmd = rrse_cmd_t'(hwdata[RRSE_CMD_W-1:0]);
  // Commands during refill or sleep are dropped, not queued
  assign issue = wr_now && (addr_reg == RRSE_OFF_CMD) && (ex_state_reg == RRSE_EX_READY) && !status_reg.asleep;
  assign do_ret = issue && (cmd.op == RRSE_OP_RETURN);
  assign do_sleep = issue && (cmd.op == RRSE_OP_SLEEP);
  assign do_rot = issue && ((cmd.op == RRSE_OP_ROTATE_LEFT_CARRY) || (cmd.op == RRSE_OP_ROTATE_RIGHT_CARRY));
  assign file_q = file_mem[cmd.faddr];
  assign sp_m1 = sp_reg - 1'b1;
  assign stack_top_entry = stack_mem[sp_m1];
  assign wdt_timeout = !status_reg.asleep && (&wdt_pre_reg) && (&wdt_cnt_reg);
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign core_sleeping = status_reg.asleep;

  always_comb begin
    if (cmd.op == RRSE_OP_ROTATE_LEFT_CARRY) begin
      rot_val = {file_q[6:0], status_reg.carry};
      rot_c = file_q[7];
    end else begin
      rot_val = {status_reg.carry, file_q[7:1]};
      rot_c = file_q[0];
    end
  end

  // One wait state per transfer keeps hrdata straight from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= RRSE_BUS_IDLE;
      hreadyout_reg <= 1'b1;
      addr_reg <= 10'h000;
      wr_reg <= 1'b0;
      size_ok_reg <= 1'b0;
    end else begin
      unique case (bus_state_reg)
        RRSE_BUS_IDLE: begin
          if (hsel && htrans[1] && hready) begin
            addr_reg <= haddr[9:0];
            wr_reg <= hwrite;
            size_ok_reg <= (hsize == RRSE_HSIZE_WORD);
            hreadyout_reg <= 1'b0;
            bus_state_reg <= RRSE_BUS_DATA;
          end
        end
        RRSE_BUS_DATA: begin
          hreadyout_reg <= 1'b1;
          size_ok_reg <= 1'b0;
          bus_state_reg <= RRSE_BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    if (addr_reg[RRSE_FILE_SEL_BIT]) begin
      rd_next[7:0] = file_mem[addr_reg[8:2]];
    end else begin
      unique case (addr_reg)
        RRSE_OFF_STATUS: begin
          rd_next[3:0] = status_reg;
          rd_next[RRSE_STATUS_BUSY_POS] = (ex_state_reg == RRSE_EX_REFILL);
        end
        RRSE_OFF_WREG: rd_next[7:0] = w_reg;
        RRSE_OFF_PC: rd_next[PC_W-1:0] = pc_reg;
        RRSE_OFF_STACK: begin
          rd_next[PC_W-1:0] = stack_top_entry;
          rd_next[RRSE_STACK_SP_POS +: SPW] = sp_reg;
        end
        RRSE_OFF_WDT: begin
          rd_next[7:0] = wdt_pre_reg;
          rd_next[RRSE_WDT_COUNT_POS +: 8] = wdt_cnt_reg;
        end
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_now) begin
      hrdata_reg <= rd_next;
    end
  end

  always_ff @(posedge hclk) begin
    if (do_rot && cmd.dest) begin
      file_mem[cmd.faddr] <= rot_val;
    end else if (wr_now && addr_reg[RRSE_FILE_SEL_BIT]) begin
      file_mem[addr_reg[8:2]] <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_reg <= RRSE_WREG_RST;
    end else if (do_rot && !cmd.dest) begin
      w_reg <= rot_val;
    end else if (wr_now && addr_reg == RRSE_OFF_WREG) begin
      w_reg <= hwdata[7:0];
    end
  end

  // Bus pushes stand in for the call path; dropped during refill like sp
  always_ff @(posedge hclk) begin
    if (wr_now && addr_reg == RRSE_OFF_STACK && ex_state_reg == RRSE_EX_READY) begin
      stack_mem[sp_reg] <= hwdata[PC_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ex_state_reg <= RRSE_EX_READY;
      sp_reg <= '0;
      pc_reg <= '0;
    end else begin
      unique case (ex_state_reg)
        RRSE_EX_READY: begin
          if (do_ret) begin
            pc_reg <= stack_top_entry;
            sp_reg <= sp_m1;
            ex_state_reg <= RRSE_EX_REFILL;
          end else if (issue) begin
            pc_reg <= pc_reg + 1'b1;
          end else if (wr_now && addr_reg == RRSE_OFF_PC) begin
            pc_reg <= hwdata[PC_W-1:0];
          end else if (wr_now && addr_reg == RRSE_OFF_STACK) begin
            sp_reg <= sp_reg + 1'b1;
          end
        end
        RRSE_EX_REFILL: ex_state_reg <= RRSE_EX_READY;
      endcase
    end
  end

  // Sleep beats a watchdog expiry landing in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= '{asleep: 1'b0, watchdog_expiry_flag: RRSE_TO_RST,
                      power_down_flag: RRSE_PD_RST, carry: RRSE_CARRY_RST};
    end else begin
      if (do_rot) begin
        status_reg.carry <= rot_c;
      end else if (wr_now && addr_reg == RRSE_OFF_STATUS) begin
        status_reg.carry <= hwdata[0];
      end
      if (do_sleep) begin
        status_reg.power_down_flag <= 1'b0;
        status_reg.watchdog_expiry_flag <= 1'b1;
        status_reg.asleep <= 1'b1;
      end else begin
        if (wdt_timeout) begin
          status_reg.watchdog_expiry_flag <= 1'b0;
        end
        if (wr_now && addr_reg == RRSE_OFF_STATUS && !hwdata[3]) begin
          status_reg.asleep <= 1'b0;
        end
      end
    end
  end

  // Watchdog halts while asleep; no wake on timeout here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_pre_reg <= 8'h00;
      wdt_cnt_reg <= 8'h00;
    end else if (do_sleep) begin
      wdt_pre_reg <= 8'h00;
      wdt_cnt_reg <= 8'h00;
    end else if (!status_reg.asleep) begin
      wdt_pre_reg <= wdt_pre_reg + 1'b1;
      if (&wdt_pre_reg) begin
        wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
      end
    end
  end

  logic [7:0] prev_file_reg;
  logic prev_carry_reg;
  logic [6:0] prev_faddr_reg;
  logic prev_timeout_reg;
  // Watchdog expiry may clear its flag in any cycle without a sleep, instruction or not
  always_ff @(posedge hclk) begin
    prev_timeout_reg <= wdt_timeout;
    prev_file_reg <= file_q;
    prev_carry_reg <= status_reg.carry;
    prev_faddr_reg <= cmd.faddr;
  end

  logic rot_l, rot_r;
  assign rot_l = do_rot && (cmd.op == RRSE_OP_ROTATE_LEFT_CARRY);
  assign rot_r = do_rot && (cmd.op == RRSE_OP_ROTATE_RIGHT_CARRY);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ret_pop;
    do_ret |=> (pc_reg == $past(stack_top_entry)) && (sp_reg == SPW'($past(sp_reg) - 1'b1))
      && $stable(status_reg.carry) && $stable(status_reg.power_down_flag) && $stable(status_reg.asleep)
      && ($stable(status_reg.watchdog_expiry_flag) || prev_timeout_reg);
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("return did not load stack top");

  property p_ret_two;
    do_ret |=> (ex_state_reg == RRSE_EX_REFILL) && !issue ##1 (ex_state_reg == RRSE_EX_READY);
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

  property p_rlf;
    rot_l && !cmd.dest |=> (w_reg == {prev_file_reg[6:0], prev_carry_reg}) && (status_reg.carry == prev_file_reg[7]);
  endproperty
  a_rlf: assert property (p_rlf) else $error("rotate left result wrong");

  property p_rrf;
    rot_r && cmd.dest |=> (file_mem[prev_faddr_reg] == {prev_carry_reg, prev_file_reg[7:1]})
      && (status_reg.carry == prev_file_reg[0]);
  endproperty
  a_rrf: assert property (p_rrf) else $error("rotate right result wrong");

  property p_dest_file;
    do_rot && cmd.dest |=> $stable(w_reg);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("W changed on file destination");

  property p_rot_flags;
    do_rot |=> $stable(status_reg.power_down_flag)
      && ($stable(status_reg.watchdog_expiry_flag) || prev_timeout_reg)
      && $stable(status_reg.asleep);
  endproperty
  a_rot_flags: assert property (p_rot_flags) else $error("rotate altered a non-carry flag");

  property p_sleep_pd;
    do_sleep |=> !status_reg.power_down_flag && status_reg.asleep;
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("sleep left power-down flag set");

  property p_sleep_to;
    do_sleep |=> status_reg.watchdog_expiry_flag [*2];
  endproperty
  a_sleep_to: assert property (p_sleep_to) else $error("sleep left expiry flag low");

  property p_sleep_wdt;
    do_sleep |=> ((wdt_cnt_reg == 8'h00) && (wdt_pre_reg == 8'h00)) [*2];
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared by sleep");

  property p_rrf_one;
    rot_r |=> (ex_state_reg == RRSE_EX_READY) && (pc_reg == PC_W'($past(pc_reg) + 1'b1));
  endproperty
  a_rrf_one: assert property (p_rrf_one) else $error("rotate right not single cycle");

  c_ret: cover property (do_ret ##2 (ex_state_reg == RRSE_EX_READY));
  c_rlf_w: cover property (rot_l && !cmd.dest);
  c_rrf_f: cover property (rot_r && cmd.dest);
  c_sleep: cover property (do_sleep ##[1:20] !status_reg.asleep);
endmodule // rrse_core

// [verification/tb_top.sv]
/*
  Self-checking bench for rrse_core: return, rotate through carry and sleep,
  all driven as single word AHB-Lite transfers. Assumes hready is fed back
  from hreadyout, one slave, one clock.
*/
`timescale 1ns/10ps
module tb_top;
  import rrse_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, core_sleeping;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int error_cnt = 0;
  int total_checks = 0;

  rrse_core dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_sleeping(core_sleeping)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Waits as long as the slave asks; only the 80000-cycle run timeout ends a hang
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic wr, input logic [9:0] off, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, off};
    hwrite <= wr;
    hsize <= RRSE_HSIZE_WORD;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rdv = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [9:0] off, input logic [31:0] exp, input string msg);
    bus(1'b0, off, 32'h0);
    chk(rdv, exp, msg);
  endtask

  function automatic logic [9:0] fa(input logic [6:0] f);
    return {1'b1, f, 2'b00};
  endfunction

  task automatic ex(input rrse_op_t op, input logic dst, input logic [6:0] f);
    rrse_cmd_t c;
    c = '{op: op, dest: dst, faddr: f};
    bus(1'b1, RRSE_OFF_CMD, {22'h0, c});
  endtask

  task automatic t_reset;
    chk_rd(RRSE_OFF_STATUS, 32'h0000_0006, "status after reset");
    chk_rd(RRSE_OFF_WREG, 32'h0000_0000, "W after reset");
    chk_rd(RRSE_OFF_PC, 32'h0000_0000, "PC after reset");
    chk_rd(10'h018, 32'h0000_0000, "unmapped read");
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask

  task automatic t_rotl;
    bus(1'b1, fa(7'h05), 32'h0000_00E6);
    bus(1'b1, RRSE_OFF_STATUS, 32'h0000_0000);
    ex(RRSE_OP_ROTATE_LEFT_CARRY, 1'b0, 7'h05);
    chk_rd(RRSE_OFF_WREG, 32'h0000_00CC, "rotl to W");
    chk_rd(fa(7'h05), 32'h0000_00E6, "rotl source kept");
    chk_rd(RRSE_OFF_STATUS, 32'h0000_0007, "rotl carry out");
    chk_rd(RRSE_OFF_PC, 32'h0000_0001, "rotl one word");
  endtask

  task automatic t_rotr;
    // Top of the address range, carry in is 1 from the rotate left
    bus(1'b1, fa(7'h7F), 32'h0000_0001);
    ex(RRSE_OP_ROTATE_RIGHT_CARRY, 1'b1, 7'h7F);
    chk_rd(fa(7'h7F), 32'h0000_0080, "rotr to file");
    chk_rd(RRSE_OFF_WREG, 32'h0000_00CC, "rotr W kept");
    chk_rd(RRSE_OFF_STATUS, 32'h0000_0007, "rotr carry out");
    ex(RRSE_OP_ROTATE_RIGHT_CARRY, 1'b0, 7'h7F);
    chk_rd(RRSE_OFF_WREG, 32'h0000_00C0, "rotr to W");
    chk_rd(RRSE_OFF_STATUS, 32'h0000_0006, "rotr carry clear");
    chk_rd(RRSE_OFF_PC, 32'h0000_0003, "rotr one word");
  endtask

  task automatic t_return;
    // Two pushes so the entry left on top after the pop is known
    bus(1'b1, RRSE_OFF_STACK, 32'h0000_0111);
    bus(1'b1, RRSE_OFF_STACK, 32'h0000_1234);
    chk_rd(RRSE_OFF_STACK, 32'h0002_1234, "stack before return");
    ex(RRSE_OP_RETURN, 1'b0, 7'h00);
    chk_rd(RRSE_OFF_PC, 32'h0000_1234, "return PC");
    chk_rd(RRSE_OFF_STACK, 32'h0001_0111, "stack popped");
    chk_rd(RRSE_OFF_STATUS, 32'h0000_0006, "return flags");
  endtask

  task automatic t_sleep;
    // Let the watchdog expire first so sleep must set the flag again
    repeat (66000) @(posedge hclk);
    chk_rd(RRSE_OFF_STATUS, 32'h0000_0002, "watchdog expired");
    ex(RRSE_OP_SLEEP, 1'b0, 7'h00);
    chk_rd(RRSE_OFF_STATUS, 32'h0000_000C, "sleep flags");
    chk_rd(RRSE_OFF_WDT, 32'h0000_0000, "sleep clears watchdog");
    chk({31'h0, core_sleeping}, 32'h1, "asleep");
    chk_rd(RRSE_OFF_PC, 32'h0000_1235, "sleep PC");
    bus(1'b1, RRSE_OFF_STATUS, 32'h0000_0000);
    @(posedge hclk);
    chk({31'h0, core_sleeping}, 32'h0, "woken");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = RRSE_HSIZE_WORD;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_rotl();
    t_rotr();
    t_return();
    t_sleep();
    give_verdict();
  end

  // Tests need about 66100 cycles
  initial begin
    repeat (80000) @(posedge hclk);
    error_cnt++;
    $display("[FAIL] %0t run timed out", $time);
    give_verdict();
  end
endmodule // tb_top
